// File: posted_write_error_queue.sv
// posted-write failure queue with head registers and posting limit
// assumes: link asks for acks, host-bus side reports landing or failure of posted writes
//
// Operation
// - while failure event set, registers hold the failed write's 48-bit offset
// - read-only field gives bus and node number of the requester
// - high register holds upper 16 offset bits, read-only
// - low register holds lower 32 offset bits, read-only
// - requester id and offset form one 64-bit value over two registers
// - failed posted write is queued and the failure event raised
// - failed packet is dropped from the fifo so traffic continues
// - on consumption, retire head, show next entry, raise event again
// - no failure events once the queue is empty
// - head is consumed as soon as the event flag is cleared
// - no more ack_complete outstanding than queue entries
// - writes beyond posting capacity get ack_pending instead
// - capacity freed only by successful landing or software retiring
// - posting may be left out: then nothing is posted or reported
// - queue depth is an implementation parameter, from 1 to 256
// - writes to posting ranges may be acked before reaching memory
// - event set keeps write pending; clearing it ends pending state
`timescale 1ns/1ns
`default_nettype none
module posted_write_error_queue
    import posted_fail_pkg::*;
#(
    parameter int QUEUE_DEPTH = DEFAULT_QUEUE_DEPTH,
    parameter bit POST_SUPPORT = 1'b1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // software control
    input wire logic postEnable,
    input wire logic eventClear,
    // physical write requests from the link
    input wire logic physWrReq,
    input wire logic physWrPostable,
    output logic ackValid_q,
    output logic ackComplete_q,
    // host-bus outcome of posted writes
    input wire logic wrLanded,
    input wire logic wrFail,
    input wire logic [REQ_ID_W-1:0] wrFailReqId,
    input wire logic [OFFSET_W-1:0] wrFailOffset,
    output logic failDrop_q,
    // software-visible state
    output logic postedFailEvent_q,
    output logic [REG_W-1:0] postedFailAddrHigh_q,
    output logic [REG_W-1:0] postedFailAddrLow_q
);

    // ------------------------------------------------------------
    // sizing
    // ------------------------------------------------------------
    localparam int AW = (QUEUE_DEPTH > 1) ? $clog2(QUEUE_DEPTH) : 1;
    localparam int CW = $clog2(QUEUE_DEPTH + 1) + 1;

    if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > 256)
    begin : g_depth_check
        $error("QUEUE_DEPTH must lie in 1..256");
    end

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        nextPtr = (p == AW'(QUEUE_DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    head_state_t headState_q;
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [CW-1:0] entryCount_q;
    logic [CW-1:0] creditCount;
    logic creditFull;
    logic grantPost;
    logic retireHead;
    logic queueWrite;
    logic [ENTRY_W-1:0] headData;

    // ------------------------------------------------------------
    // posting decision
    // ------------------------------------------------------------
    // capacity counts in-flight and failed-but-queued writes alike
    assign grantPost = POST_SUPPORT && postEnable && physWrReq && physWrPostable
                       && !creditFull;
    assign retireHead = (headState_q == HEAD_SHOW) && postedFailEvent_q && eventClear;
    assign queueWrite = POST_SUPPORT && wrFail;

    post_credit_counter #(
        .DEPTH(QUEUE_DEPTH),
        .CW(CW)
    ) u_credit (
        .clk(clk),
        .rst_n(rst_n),
        .take(grantPost),
        .landed(wrLanded),
        .retired(retireHead),
        .count_q(creditCount),
        .full_q(creditFull)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ackValid_q <= 1'b0;
            ackComplete_q <= 1'b0;
        end
        else
        begin
            ackValid_q <= physWrReq;
            ackComplete_q <= grantPost;
        end
    end

    // ------------------------------------------------------------
    // failure queue
    // ------------------------------------------------------------
    err_queue_mem #(
        .DEPTH(QUEUE_DEPTH),
        .WIDTH(ENTRY_W),
        .AW(AW)
    ) u_mem (
        .clk(clk),
        .wrEn(queueWrite),
        .wrAddr(wrPtr_q),
        .wrData({wrFailReqId, wrFailOffset}),
        .rdAddr(rdPtr_q),
        .rdData_q(headData)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end
        else
        begin
            if (queueWrite)
            begin
                wrPtr_q <= nextPtr(wrPtr_q);
            end
            if (retireHead)
            begin
                rdPtr_q <= nextPtr(rdPtr_q);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            entryCount_q <= '0;
        end
        else
        begin
            entryCount_q <= CW'(entryCount_q + CW'(queueWrite) - CW'(retireHead));
        end
    end

    // the failed packet leaves the fifo at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            failDrop_q <= 1'b0;
        end
        else
        begin
            failDrop_q <= queueWrite;
        end
    end

    // ------------------------------------------------------------
    // head presentation
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            headState_q <= HEAD_IDLE;
        end
        else
        begin
            unique case (headState_q)
                HEAD_IDLE:
                begin
                    if (entryCount_q != '0)
                    begin
                        headState_q <= HEAD_FETCH;
                    end
                end
                HEAD_FETCH:
                begin
                    headState_q <= HEAD_LOAD;
                end
                HEAD_LOAD:
                begin
                    headState_q <= HEAD_SHOW;
                end
                HEAD_SHOW:
                begin
                    if (retireHead)
                    begin
                        headState_q <= HEAD_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            postedFailEvent_q <= EVENT_RESET;
        end
        else if (headState_q == HEAD_LOAD)
        begin
            postedFailEvent_q <= 1'b1;
        end
        else if (retireHead)
        begin
            postedFailEvent_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            postedFailAddrHigh_q <= ADDR_HIGH_RESET;
            postedFailAddrLow_q <= ADDR_LOW_RESET;
        end
        else if (headState_q == HEAD_LOAD)
        begin
            // requester id above upper offset, lower offset alone
            postedFailAddrHigh_q <= {headData[ENTRY_W-1 -: REQ_ID_W],
                                     headData[OFFSET_W-1 -: OFFSET_UPPER_W]};
            postedFailAddrLow_q <= headData[OFFSET_LOWER_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence seqRetire;
        postedFailEvent_q && eventClear;
    endsequence

    sequence seqMoreQueued;
        entryCount_q > CW'(1);
    endsequence

    a_ack_answer: assert property (@(posedge clk) disable iff (!rst_n)
        physWrReq |=> ackValid_q && (ackComplete_q == $past(grantPost)))
        else $error("ack answer wrong");

    a_no_overpost: assert property (@(posedge clk) disable iff (!rst_n)
        physWrReq && creditFull |=> ackValid_q && !ackComplete_q)
        else $error("ack_complete given while full");

    a_credit_bound: assert property (@(posedge clk) disable iff (!rst_n)
        creditCount <= CW'(QUEUE_DEPTH))
        else $error("outstanding posts exceed depth");

    a_disabled_none: assert property (@(posedge clk) disable iff (!rst_n)
        physWrReq && !postEnable |=> !ackComplete_q)
        else $error("posted while disabled");

    a_fail_drop: assert property (@(posedge clk) disable iff (!rst_n)
        queueWrite |=> failDrop_q && entryCount_q == CW'($past(entryCount_q) + 1'b1 - CW'($past(retireHead))))
        else $error("failed write not queued or dropped");

    a_head_load: assert property (@(posedge clk) disable iff (!rst_n)
        headState_q == HEAD_LOAD |=> postedFailEvent_q
            && postedFailAddrLow_q == $past(headData[OFFSET_LOWER_W-1:0])
            && postedFailAddrHigh_q[OFFSET_UPPER_W-1:0] == $past(headData[OFFSET_W-1 -: OFFSET_UPPER_W]))
        else $error("head registers not loaded");

    a_first_event: assert property (@(posedge clk) disable iff (!rst_n)
        headState_q == HEAD_IDLE && !postedFailEvent_q && entryCount_q != '0 |-> ##3 postedFailEvent_q)
        else $error("event not raised for queued entry");

    a_reload_next: assert property (@(posedge clk) disable iff (!rst_n)
        seqRetire ##0 seqMoreQueued |=> !postedFailEvent_q ##3 postedFailEvent_q)
        else $error("next entry not presented");

    a_empty_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        seqRetire ##0 (entryCount_q == CW'(1)) ##1 (entryCount_q == '0) [*3] |-> !postedFailEvent_q)
        else $error("event raised with empty queue");

    a_clear_frees: assert property (@(posedge clk) disable iff (!rst_n)
        seqRetire ##0 !grantPost ##0 !wrLanded |=> creditCount == CW'($past(creditCount) - 1'b1))
        else $error("retire did not free capacity");

    a_fail_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        queueWrite && !grantPost && !wrLanded && !retireHead |=> creditCount == $past(creditCount))
        else $error("failure freed capacity");

    a_land_frees: assert property (@(posedge clk) disable iff (!rst_n)
        wrLanded && !grantPost && !retireHead && creditCount != '0
            |=> creditCount == CW'($past(creditCount) - 1'b1))
        else $error("landing did not free capacity");

    a_drop_only: assert property (@(posedge clk) disable iff (!rst_n)
        !queueWrite |=> !failDrop_q)
        else $error("drop without failure");

    a_event_nonempty: assert property (@(posedge clk) disable iff (!rst_n)
        postedFailEvent_q |-> entryCount_q != '0)
        else $error("event raised with no entry");

    a_event_shown: assert property (@(posedge clk) disable iff (!rst_n)
        postedFailEvent_q |-> headState_q == HEAD_SHOW)
        else $error("event set without a shown head");

    a_queue_bound: assert property (@(posedge clk) disable iff (!rst_n)
        entryCount_q <= CW'(QUEUE_DEPTH))
        else $error("queue holds more than its depth");

    a_regs_hold: assert property (@(posedge clk) disable iff (!rst_n)
        postedFailEvent_q |=> $stable(postedFailAddrHigh_q) && $stable(postedFailAddrLow_q))
        else $error("address registers moved while event set");

    a_stray_clear: assert property (@(posedge clk) disable iff (!rst_n)
        eventClear && !postedFailEvent_q |=> $stable(rdPtr_q))
        else $error("clear without event advanced the queue");

    a_nopost_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        !POST_SUPPORT |-> !ackComplete_q && !failDrop_q && !postedFailEvent_q)
        else $error("posting activity without posting support");

endmodule
`default_nettype wire

// File: posted_fail_pkg.sv
// package of constants for the posted-write failure queue
// assumes: included before every design file of the block
package posted_fail_pkg;

    // ------------------------------------------------------------
    // failure-address register layout
    // ------------------------------------------------------------
    localparam int REG_W = 32;
    localparam int OFFSET_W = 48;
    localparam int REQ_ID_W = 16;
    localparam int REQ_ID_LSB = 16;
    localparam int OFFSET_UPPER_LSB = 0;
    localparam int OFFSET_UPPER_W = 16;
    localparam int OFFSET_LOWER_LSB = 0;
    localparam int OFFSET_LOWER_W = 32;
    localparam int BUS_INDEX_LSB = 6;
    localparam int NODE_INDEX_W = 6;
    localparam int ENTRY_W = REQ_ID_W + OFFSET_W;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_HIGH_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_LOW_RESET = 32'h0000_0000;
    localparam logic EVENT_RESET = 1'b0;

    // ------------------------------------------------------------
    // defaults and timing
    // ------------------------------------------------------------
    localparam int DEFAULT_QUEUE_DEPTH = 4;
    localparam int ACK_LATENCY_CYCLES = 1;

    // ------------------------------------------------------------
    // head presentation states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HEAD_IDLE,
        HEAD_FETCH,
        HEAD_LOAD,
        HEAD_SHOW
    } head_state_t;

endpackage

// File: err_queue_mem.sv
// small memory holding failed posted-write entries
// assumes: one write port, one read port, read data registered
`timescale 1ns/1ns
`default_nettype none
module err_queue_mem
    import posted_fail_pkg::*;
#(
    parameter int DEPTH = DEFAULT_QUEUE_DEPTH,
    parameter int WIDTH = ENTRY_W,
    parameter int AW = 2
)
(
    // clock
    input wire logic clk,
    // write side
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read side
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData_q
);

    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH < 1 || DEPTH > (1 << AW))
    begin : g_depth_check
        $error("DEPTH must lie in 1..2**AW");
    end

    always_ff @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk)
    begin
        rdData_q <= mem[rdAddr];
    end

endmodule
`default_nettype wire

// File: post_credit_counter.sv
// counter of outstanding posted writes against the queue depth
// assumes: take, landed and retired are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module post_credit_counter
    import posted_fail_pkg::*;
#(
    parameter int DEPTH = DEFAULT_QUEUE_DEPTH,
    parameter int CW = 3
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // credit events
    input wire logic take,
    input wire logic landed,
    input wire logic retired,
    // state
    output logic [CW-1:0] count_q,
    output logic full_q
);

    logic [CW-1:0] count_d;

    if (DEPTH < 1 || DEPTH >= (1 << CW))
    begin : g_width_check
        $error("CW too narrow for DEPTH");
    end

    always_comb
    begin
        count_d = count_q;
        if (take)
        begin
            count_d = CW'(count_d + 1'b1);
        end
        if (landed && count_d != '0)
        begin
            count_d = CW'(count_d - 1'b1);
        end
        if (retired && count_d != '0)
        begin
            count_d = CW'(count_d - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= '0;
            full_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            full_q <= (count_d >= CW'(DEPTH));
        end
    end

endmodule
`default_nettype wire

// File: remote_node_model.sv
// model of the remote nodes that send physical write requests
// assumes: ack answer is registered one cycle after the request edge
`timescale 1ns/1ns
`default_nettype none
module remote_node_model
(
    // clock
    input wire logic clk,
    // request side
    output logic physWrReq,
    output logic physWrPostable,
    // ack side
    input wire logic ackValid_q,
    input wire logic ackComplete_q
);
    // ----------------------------------------
    // idle levels
    // ----------------------------------------
    initial
    begin
        physWrReq = 1'b0;
        physWrPostable = 1'b0;
    end

    // ----------------------------------------
    // one write request and its ack
    // ----------------------------------------
    task automatic issue(input logic postable, output logic valid, output logic complete);
        @(posedge clk);
        physWrReq <= 1'b1;
        physWrPostable <= postable;
        @(posedge clk);
        physWrReq <= 1'b0;
        // released qualifier shows the inverse, not a stale value
        physWrPostable <= ~postable;
        #1;
        valid = ackValid_q;
        complete = ackComplete_q;
    endtask
endmodule
`default_nettype wire

// File: posted_write_error_queue_test.sv
// self-checking bench of the posted-write failure queue
// assumes: design package compiled first, remote node model available
`timescale 1ns/1ns
`default_nettype none
module posted_write_error_queue_test;
    import posted_fail_pkg::*;
    localparam int DEPTH = 2;
    logic clk;
    logic rst_n;
    logic postEnable;
    logic eventClear;
    logic wrLanded;
    logic wrFail;
    logic [REQ_ID_W-1:0] wrFailReqId;
    logic [OFFSET_W-1:0] wrFailOffset;
    logic physWrReq;
    logic physWrPostable;
    logic ackValid_q;
    logic ackComplete_q;
    logic failDrop_q;
    logic postedFailEvent_q;
    logic [REG_W-1:0] postedFailAddrHigh_q;
    logic [REG_W-1:0] postedFailAddrLow_q;
    logic ackValidNp;
    logic ackCompleteNp;
    logic failDropNp;
    logic eventNp;
    int fails;
    int checks;

    // ----------------------------------------
    // instances
    // ----------------------------------------
    posted_write_error_queue #(.QUEUE_DEPTH(DEPTH), .POST_SUPPORT(1'b1)) u_dut (
        .clk(clk), .rst_n(rst_n), .postEnable(postEnable), .eventClear(eventClear),
        .physWrReq(physWrReq), .physWrPostable(physWrPostable), .ackValid_q(ackValid_q),
        .ackComplete_q(ackComplete_q), .wrLanded(wrLanded), .wrFail(wrFail), .wrFailReqId(wrFailReqId),
        .wrFailOffset(wrFailOffset), .failDrop_q(failDrop_q), .postedFailEvent_q(postedFailEvent_q),
        .postedFailAddrHigh_q(postedFailAddrHigh_q), .postedFailAddrLow_q(postedFailAddrLow_q));
    posted_write_error_queue #(.QUEUE_DEPTH(DEPTH), .POST_SUPPORT(1'b0)) u_nopost (
        .clk(clk), .rst_n(rst_n), .postEnable(postEnable), .eventClear(eventClear),
        .physWrReq(physWrReq), .physWrPostable(physWrPostable), .ackValid_q(ackValidNp),
        .ackComplete_q(ackCompleteNp), .wrLanded(wrLanded), .wrFail(wrFail), .wrFailReqId(wrFailReqId),
        .wrFailOffset(wrFailOffset), .failDrop_q(failDropNp), .postedFailEvent_q(eventNp),
        .postedFailAddrHigh_q(), .postedFailAddrLow_q());
    remote_node_model u_node (
        .clk(clk), .physWrReq(physWrReq), .physWrPostable(physWrPostable),
        .ackValid_q(ackValid_q), .ackComplete_q(ackComplete_q));

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic chk1(input string name, input logic exp, input logic got);
        checks = checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out;
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // bus actions
    // ----------------------------------------
    task automatic post(input logic postable, input logic expComplete);
        logic v;
        logic c;
        u_node.issue(postable, v, c);
        chk1("ackValid", 1'b1, v);
        chk1("ackComplete", expComplete, c);
        chk1("ackValidNoPost", 1'b1, ackValidNp);
        chk1("ackCompleteNoPost", 1'b0, ackCompleteNp);
    endtask

    task automatic land;
        @(posedge clk);
        wrLanded <= 1'b1;
        @(posedge clk);
        wrLanded <= 1'b0;
    endtask

    task automatic fail_write(input logic [15:0] id, input logic [47:0] off);
        @(posedge clk);
        wrFail <= 1'b1;
        wrFailReqId <= id;
        wrFailOffset <= off;
        @(posedge clk);
        wrFail <= 1'b0;
        wrFailReqId <= ~id;
        wrFailOffset <= ~off;
        #1;
        chk1("failDrop", 1'b1, failDrop_q);
        chk1("failDropNoPost", 1'b0, failDropNp);
    endtask

    task automatic sw_clear(input logic [15:0] id, input logic [47:0] off);
        chk32("addrHigh", {id, off[47:32]}, postedFailAddrHigh_q);
        chk32("addrLow", off[31:0], postedFailAddrLow_q);
        @(posedge clk);
        eventClear <= 1'b1;
        @(posedge clk);
        eventClear <= 1'b0;
        #1;
        chk1("eventAfterClear", 1'b0, postedFailEvent_q);
    endtask

    task automatic event_rise(input logic expRise);
        repeat (2) @(posedge clk);
        #1;
        chk1("eventEarly", 1'b0, postedFailEvent_q);
        @(posedge clk);
        #1;
        chk1("eventRise", expRise, postedFailEvent_q);
        chk1("eventNoPost", 1'b0, eventNp);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk1("eventReset", EVENT_RESET, postedFailEvent_q);
        chk1("ackValidReset", 1'b0, ackValid_q);
        chk32("addrHighReset", ADDR_HIGH_RESET, postedFailAddrHigh_q);
        chk32("addrLowReset", ADDR_LOW_RESET, postedFailAddrLow_q);
    endtask

    task automatic t_refuse;
        @(posedge clk);
        postEnable <= 1'b0;
        post(1'b1, 1'b0);
        @(posedge clk);
        postEnable <= 1'b1;
        post(1'b0, 1'b0);
        @(posedge clk);
        eventClear <= 1'b1;
        @(posedge clk);
        eventClear <= 1'b0;
        #1;
        chk1("eventStray", 1'b0, postedFailEvent_q);
    endtask

    task automatic t_limit;
        post(1'b1, 1'b1);
        post(1'b1, 1'b1);
        post(1'b1, 1'b0);
        land();
        post(1'b1, 1'b1);
        post(1'b1, 1'b0);
        land();
        land();
    endtask

    task automatic t_fail;
        post(1'b1, 1'b1);
        post(1'b1, 1'b1);
        fail_write(16'h0a85, 48'h1234_5678_9abc);
        event_rise(1'b1);
        fail_write(16'hffc2, 48'hfedc_ba98_7654);
        chk1("eventHeld", 1'b1, postedFailEvent_q);
        post(1'b1, 1'b0);
        sw_clear(16'h0a85, 48'h1234_5678_9abc);
        event_rise(1'b1);
        post(1'b1, 1'b1);
        sw_clear(16'hffc2, 48'hfedc_ba98_7654);
        event_rise(1'b0);
        post(1'b1, 1'b1);
        post(1'b1, 1'b0);
        land();
        land();
    endtask

    // ----------------------------------------
    // clock, reset, sequence, watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        fails = 0;
        checks = 0;
        rst_n = 1'b0;
        postEnable = 1'b1;
        eventClear = 1'b0;
        wrLanded = 1'b0;
        wrFail = 1'b0;
        wrFailReqId = 16'h0000;
        wrFailOffset = 48'h0000_0000_0000;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_refuse();
        t_limit();
        t_fail();
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fails = fails + 1;
        close_out();
    end
endmodule
`default_nettype wire
